// ---- hw/tchcd_defines.vh ----
// Constants for the tape controller host command decoder
//
// Function
// R1: Function word bits 11-15 zero, else ignored
// R2: Bits 7-10 must equal equipment number
// R3: Bits 2-6 have no effect
// R4: Bits 0-1 plus direction select operation
// R5: Direct mode uses accumulator channel only
// R6: Host issues motion function, then word instructions
// R7: Buffered mode moves data via storage channel
// R8: Up to four daisy-chained drives, one selected
// R9: Pack/unpack 16-bit words; return status
// R10: Selector decode per direction as tabled
// R11: Buffered start fetches last address at first-minus-one; code uses that word as last address plus one
// R12: Equipment number is static four-bit setting
`ifndef TCHCD_DEFINES_VH
`define TCHCD_DEFINES_VH

// Function word fields
`define TCHCD_ZERO_HI      15
`define TCHCD_ZERO_LO      11
`define TCHCD_EQ_HI        10
`define TCHCD_EQ_LO        7
`define TCHCD_OP_HI        1
`define TCHCD_OP_LO        0

// Operation selector codes, output / input meaning
`define TCHCD_OP_DATA      2'h0
`define TCHCD_OP_CTRL      2'h1
`define TCHCD_OP_UNIT      2'h2
`define TCHCD_OP_BUF       2'h3

// Control function word fields
`define TCHCD_CF_CLR_CTL   0
`define TCHCD_CF_CLR_INT   1
`define TCHCD_CF_MOT_HI    10
`define TCHCD_CF_MOT_LO    7

// Motion codes
`define TCHCD_MOT_NONE     4'h0
`define TCHCD_MOT_WRITE    4'h1
`define TCHCD_MOT_READ     4'h2
`define TCHCD_MOT_BACK     4'h3
`define TCHCD_MOT_WFM      4'h5
`define TCHCD_MOT_SFMF     4'h6
`define TCHCD_MOT_SFMB     4'h7
`define TCHCD_MOT_RWLD     4'h8
`define TCHCD_MOT_RWUL     4'hC

// Unit select field in the data word
`define TCHCD_UNIT_HI      1
`define TCHCD_UNIT_LO      0

// First status word bit positions
`define TCHCD_ST1_EOP      0
`define TCHCD_ST1_ARMED    1
`define TCHCD_ST1_XFER     2
`define TCHCD_ST1_WR_FULL  3
`define TCHCD_ST1_RD_AVAIL 4
`define TCHCD_ST1_BUF_MODE 5

// Reset values
`define TCHCD_RST_WORD     16'h0000
`define TCHCD_RST_UNIT     2'h0

`endif

// ---- hw/tchcd_pack.v ----
// Character packer and unpacker between host words and tape characters
`timescale 1ns/1ps
module tchcd_pack #(
   parameter CHAR_W = 8                          // Tape character width
) (
   input  wire                clk,
   input  wire                rst_n,
   input  wire [2*CHAR_W-1:0] wr_word,           // Host word to unpack
   input  wire                wr_valid,
   output wire                wr_ready,
   output reg  [CHAR_W-1:0]   char_out,          // Character toward tape
   output reg                 char_out_valid,
   input  wire                char_out_ready,
   input  wire [CHAR_W-1:0]   char_in,           // Character from tape
   input  wire                char_in_valid,
   output wire                char_in_ready,
   output reg  [2*CHAR_W-1:0] rd_word,           // Packed host word
   output reg                 rd_valid,
   input  wire                rd_ready
);
   reg [CHAR_W-1:0] low_hold;                    // Second character of word
   reg              low_pend;                    // Second character owed
   reg [CHAR_W-1:0] high_hold;                   // First character received
   reg              high_have;                   // First half collected

   // Take a new word only when both halves are gone
   assign wr_ready      = ~char_out_valid & ~low_pend;
   // Stall the tape while a packed word waits for the host
   assign char_in_ready = ~rd_valid;

   // Unpack: high character first, then low character
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         char_out       <= {CHAR_W{1'b0}};
         char_out_valid <= 1'b0;
         low_hold       <= {CHAR_W{1'b0}};
         low_pend       <= 1'b0;
      end else if (char_out_valid && char_out_ready) begin
         // Current character taken; send the owed one if any
         char_out_valid <= low_pend;
         char_out       <= low_hold;
         low_pend       <= 1'b0;
      end else if (wr_valid && wr_ready) begin
         char_out       <= wr_word[2*CHAR_W-1:CHAR_W];
         char_out_valid <= 1'b1;
         low_hold       <= wr_word[CHAR_W-1:0];
         low_pend       <= 1'b1;
      end
   end

   // Pack: first character lands in the high half
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         high_hold <= {CHAR_W{1'b0}};
         high_have <= 1'b0;
         rd_word   <= {2*CHAR_W{1'b0}};
         rd_valid  <= 1'b0;
      end else begin
         if (rd_valid && rd_ready) begin
            rd_valid <= 1'b0;
         end
         if (char_in_valid && char_in_ready) begin
            if (high_have) begin
               rd_word   <= {high_hold, char_in};
               rd_valid  <= 1'b1;
               high_have <= 1'b0;
            end else begin
               high_hold <= char_in;
               high_have <= 1'b1;
            end
         end
      end
   end
endmodule // tchcd_pack

// ---- hw/tchcd_top.v ----
// Host command decoder and transfer front end of the tape controller
`timescale 1ns/1ps
`include "tchcd_defines.vh"
module tchcd_top #(
   parameter CHAR_W = 8                          // Tape character width
) (
   input  wire              CLK,
   input  wire              RST_N,
   input  wire [3:0]        EQUIP_NUM,           // Jumpered equipment number
   input  wire              HQ_STROBE,           // Host instruction pulse
   input  wire              HQ_OUTPUT,           // 1 output from A, 0 input to A
   input  wire [15:0]       HQ_FUNC,             // Function/address word
   input  wire [15:0]       HQ_DATA,             // Accumulator word on output
   output reg               HQ_REPLY,            // Instruction accepted
   output reg               HQ_REJECT,           // Instruction refused
   output reg  [15:0]       HQ_RDATA,            // Word returned on input
   output reg               SA_REQ,              // Storage channel request
   output reg               SA_WRITE,            // 1 store to memory
   output reg  [15:0]       SA_ADDR,
   output reg  [15:0]       SA_WDATA,
   input  wire              SA_ACK,              // Storage channel done
   input  wire [15:0]       SA_RDATA,
   output reg  [1:0]        TAPE_UNIT,           // Selected tape drive
   output reg  [3:0]        TAPE_MOTION,         // Motion code
   output reg               TAPE_MOTION_GO,      // Motion start pulse
   output wire [CHAR_W-1:0] TAPE_WR_CHAR,
   output wire              TAPE_WR_VALID,
   input  wire              TAPE_WR_READY,
   input  wire [CHAR_W-1:0] TAPE_RD_CHAR,
   input  wire              TAPE_RD_VALID,
   output wire              TAPE_RD_READY,
   input  wire              TAPE_EOP             // Drive finished operation
);
   // Buffered engine states
   localparam S_IDLE  = 2'h0;                    // No buffered job
   localparam S_FETCH = 2'h1;                    // Reading end address
   localparam S_ARMED = 2'h2;                    // Waiting for motion
   localparam S_XFER  = 2'h3;                    // Moving words

   reg  [3:0]  eq_meta;                          // Jumper sync stage one
   reg  [3:0]  eq_num;                           // Jumper sync stage two
   reg  [1:0]  state;                            // Buffered engine state
   reg  [15:0] cur_addr;                         // Current buffer address
   reg  [15:0] last_addr;                        // Last address plus one
   reg         eop;                              // Operation ended
   reg  [15:0] wr_word;                          // Word owed to the tape
   reg         wr_have;                          // Word waiting for packer
   wire [15:0] rd_word;                          // Packed word from tape
   wire        rd_valid;
   wire        wr_ready;
   wire        hit;                              // Instruction addressed to us
   wire [1:0]  op;
   wire [3:0]  mot;
   wire        buf_mode;
   wire        mot_legal;
   wire        dir_wr_ok;
   wire        dir_rd_ok;
   wire        xfer_rd;
   wire        rd_take;

   // Equipment number jumpers pass two flops
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         eq_meta <= 4'h0;
         eq_num  <= 4'h0;
      end else begin
         eq_meta <= EQUIP_NUM; // R12
         eq_num  <= eq_meta;
      end
   end

   // Selection: high bits zero and equipment field match; bits 2-6 unused
   assign hit = HQ_STROBE & (HQ_FUNC[`TCHCD_ZERO_HI:`TCHCD_ZERO_LO] == 5'h00) // R1
              & (HQ_FUNC[`TCHCD_EQ_HI:`TCHCD_EQ_LO] == eq_num); // R2 R3
   assign op  = HQ_FUNC[`TCHCD_OP_HI:`TCHCD_OP_LO]; // R4
   assign mot = HQ_DATA[`TCHCD_CF_MOT_HI:`TCHCD_CF_MOT_LO];

   // Buffered mode once the start instruction arrived
   assign buf_mode = (state != S_IDLE);

   // Motion codes that the drive knows
   assign mot_legal = (mot == `TCHCD_MOT_NONE) | (mot == `TCHCD_MOT_WRITE) | (mot == `TCHCD_MOT_READ)
                    | (mot == `TCHCD_MOT_BACK) | (mot == `TCHCD_MOT_WFM) | (mot == `TCHCD_MOT_SFMF)
                    | (mot == `TCHCD_MOT_SFMB) | (mot == `TCHCD_MOT_RWLD) | (mot == `TCHCD_MOT_RWUL);

   // Direct word transfer allowed over the accumulator channel
   // A write also waits until the packer has sent both characters
   assign dir_wr_ok = ~buf_mode & (TAPE_MOTION == `TCHCD_MOT_WRITE) & ~wr_have & wr_ready; // R5
   assign dir_rd_ok = ~buf_mode & (TAPE_MOTION == `TCHCD_MOT_READ) & rd_valid; // R5

   // Buffered read: a packed word goes to memory when channel is free
   assign xfer_rd = (state == S_XFER) & (TAPE_MOTION == `TCHCD_MOT_READ)
                  & ~SA_REQ & rd_valid & (cur_addr != last_addr); // R7

   // Packed word leaves on a direct read or a buffered store
   assign rd_take = (hit & ~HQ_OUTPUT & (op == `TCHCD_OP_DATA) & dir_rd_ok) | xfer_rd;

   // Host instruction decode and answer, one cycle after the strobe
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         HQ_REPLY       <= 1'b0;
         HQ_REJECT      <= 1'b0;
         HQ_RDATA       <= `TCHCD_RST_WORD;
         TAPE_UNIT      <= `TCHCD_RST_UNIT;
         TAPE_MOTION    <= `TCHCD_MOT_NONE;
         TAPE_MOTION_GO <= 1'b0;
         eop            <= 1'b1;
      end else begin
         HQ_REPLY       <= 1'b0;
         HQ_REJECT      <= 1'b0;
         TAPE_MOTION_GO <= 1'b0;
         if (hit && HQ_OUTPUT) begin
            case (op) // R10
               `TCHCD_OP_DATA: begin
                  HQ_REPLY  <= dir_wr_ok; // R5
                  HQ_REJECT <= ~dir_wr_ok;
               end
               `TCHCD_OP_CTRL: begin
                  if (!mot_legal) begin
                     HQ_REJECT <= 1'b1;
                  end else begin
                     HQ_REPLY <= 1'b1;
                     if (HQ_DATA[`TCHCD_CF_CLR_CTL]) begin
                        // Clear keeps the unit selection
                        TAPE_MOTION <= `TCHCD_MOT_NONE;
                        eop         <= 1'b1;
                     end
                     if (mot != `TCHCD_MOT_NONE) begin
                        // New motion; host follows with data words
                        TAPE_MOTION    <= mot; // R6
                        TAPE_MOTION_GO <= 1'b1;
                        eop            <= 1'b0;
                     end
                  end
               end
               `TCHCD_OP_UNIT: begin
                  TAPE_UNIT <= HQ_DATA[`TCHCD_UNIT_HI:`TCHCD_UNIT_LO]; // R8
                  HQ_REPLY  <= 1'b1;
               end
               default: begin
                  // Buffered start needs an idle engine
                  HQ_REPLY  <= ~buf_mode; // R7
                  HQ_REJECT <= buf_mode;
               end
            endcase
         end else if (hit) begin
            HQ_REPLY <= 1'b1;
            case (op) // R10
               `TCHCD_OP_DATA: begin
                  HQ_RDATA  <= rd_word; // R9
                  HQ_REPLY  <= dir_rd_ok;
                  HQ_REJECT <= ~dir_rd_ok;
               end
               `TCHCD_OP_CTRL: begin
                  HQ_RDATA <= {10'h000, buf_mode, rd_valid, wr_have, (state == S_XFER),
                               (state == S_ARMED), eop}; // R9
               end
               `TCHCD_OP_UNIT: begin
                  HQ_RDATA <= {8'h00, TAPE_MOTION, 2'h0, TAPE_UNIT};
               end
               default: begin
                  HQ_RDATA <= cur_addr;
               end
            endcase
         end
         // Drive end or buffer end sets end of operation; set beats a new motion
         if (TAPE_EOP || ((state == S_XFER) && (cur_addr == last_addr) && !SA_REQ && !wr_have)) begin
            eop <= 1'b1;
         end
      end
   end

   // Buffered engine and storage channel
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state     <= S_IDLE;
         cur_addr  <= `TCHCD_RST_WORD;
         last_addr <= `TCHCD_RST_WORD;
         SA_REQ    <= 1'b0;
         SA_WRITE  <= 1'b0;
         SA_ADDR   <= `TCHCD_RST_WORD;
         SA_WDATA  <= `TCHCD_RST_WORD;
         wr_word   <= `TCHCD_RST_WORD;
         wr_have   <= 1'b0;
      end else begin
         // Packer took the waiting word
         if (wr_have && wr_ready) begin
            wr_have <= 1'b0;
         end
         // Direct output word from the accumulator
         if (hit && HQ_OUTPUT && (op == `TCHCD_OP_DATA) && dir_wr_ok) begin
            wr_word <= HQ_DATA; // R5 R9
            wr_have <= 1'b1;
         end
         // Clear controller abandons a buffered job
         if (hit && HQ_OUTPUT && (op == `TCHCD_OP_CTRL) && mot_legal && HQ_DATA[`TCHCD_CF_CLR_CTL]) begin
            state  <= S_IDLE;
            SA_REQ <= 1'b0;
         end else begin
            case (state)
               S_IDLE: begin
                  if (hit && HQ_OUTPUT && (op == `TCHCD_OP_BUF)) begin
                     // Fetch end address from the word before the buffer
                     cur_addr <= HQ_DATA;
                     SA_ADDR  <= HQ_DATA - 16'h0001; // R11
                     SA_WRITE <= 1'b0;
                     SA_REQ   <= 1'b1;
                     state    <= S_FETCH;
                  end
               end
               S_FETCH: begin
                  if (SA_ACK) begin
                     last_addr <= SA_RDATA; // R11
                     SA_REQ    <= 1'b0;
                     state     <= S_ARMED;
                  end
               end
               S_ARMED: begin
                  // Wait for read or write motion
                  if (hit && HQ_OUTPUT && (op == `TCHCD_OP_CTRL) && mot_legal
                      && ((mot == `TCHCD_MOT_READ) || (mot == `TCHCD_MOT_WRITE))) begin
                     state <= S_XFER; // R11
                  end
               end
               S_XFER: begin
                  if (SA_REQ) begin
                     if (SA_ACK) begin
                        SA_REQ   <= 1'b0;
                        cur_addr <= cur_addr + 16'h0001;
                        if (!SA_WRITE) begin
                           wr_word <= SA_RDATA; // R7
                           wr_have <= 1'b1;
                        end
                     end
                  end else if (cur_addr == last_addr) begin
                     if (!wr_have) begin
                        state <= S_IDLE;
                     end
                  end else if (xfer_rd) begin
                     SA_ADDR  <= cur_addr; // R7
                     SA_WDATA <= rd_word;
                     SA_WRITE <= 1'b1;
                     SA_REQ   <= 1'b1;
                  end else if ((TAPE_MOTION == `TCHCD_MOT_WRITE) && !wr_have) begin
                     SA_ADDR  <= cur_addr; // R7
                     SA_WRITE <= 1'b0;
                     SA_REQ   <= 1'b1;
                  end
               end
               default: begin
                  state <= S_IDLE;
               end
            endcase
         end
      end
   end

   // Word to character conversion toward and from the drive
   tchcd_pack #(
      .CHAR_W         (CHAR_W)
   ) u_pack (
      .clk            (CLK),
      .rst_n          (RST_N),
      .wr_word        (wr_word),
      .wr_valid       (wr_have),
      .wr_ready       (wr_ready),
      .char_out       (TAPE_WR_CHAR),
      .char_out_valid (TAPE_WR_VALID),
      .char_out_ready (TAPE_WR_READY),
      .char_in        (TAPE_RD_CHAR),
      .char_in_valid  (TAPE_RD_VALID),
      .char_in_ready  (TAPE_RD_READY),
      .rd_word        (rd_word),
      .rd_valid       (rd_valid),
      .rd_ready       (rd_take)
   ); // R9
endmodule // tchcd_top

// ---- tb/tchcd_mem_model.sv ----
// Host storage behind the storage access channel
`timescale 1ns/1ps
module tchcd_mem_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [1:0]  lat,                // Wait states before each answer
   input  wire logic        sa_req,
   input  wire logic        sa_write,
   input  wire logic [15:0] sa_addr,
   input  wire logic [15:0] sa_wdata,
   output reg               sa_ack,
   output reg        [15:0] sa_rdata
);
   reg [15:0] mem [0:255];                      // Storage window
   reg [1:0]  wt;                               // Wait states served
   // One word per request; data is not held after the answer
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sa_ack <= 1'b0;
         wt <= 2'h0;
         sa_rdata <= 16'hFFFF;
      end else if (sa_ack) begin
         sa_ack <= 1'b0;
         wt <= 2'h0;
         sa_rdata <= ~sa_rdata;
      end else if (sa_req && wt >= lat) begin
         sa_ack <= 1'b1;
         if (sa_write) mem[sa_addr[7:0]] <= sa_wdata;
         else sa_rdata <= mem[sa_addr[7:0]];
      end else if (sa_req) wt <= wt + 2'h1;
   end
endmodule // tchcd_mem_model

// ---- tb/tchcd_properties.sv ----
// Concurrent checks on the host command decoder ports
`timescale 1ns/1ps
module tchcd_properties #(
   parameter CHAR_W = 8                         // Tape character width
) (
   input wire logic              CLK,
   input wire logic              RST_N,
   input wire logic [3:0]        EQUIP_NUM,
   input wire logic              HQ_STROBE,
   input wire logic              HQ_OUTPUT,
   input wire logic [15:0]       HQ_FUNC,
   input wire logic [15:0]       HQ_DATA,
   input wire logic              HQ_REPLY,
   input wire logic              HQ_REJECT,
   input wire logic [15:0]       HQ_RDATA,
   input wire logic              SA_REQ,
   input wire logic              SA_WRITE,
   input wire logic [15:0]       SA_ADDR,
   input wire logic [15:0]       SA_WDATA,
   input wire logic              SA_ACK,
   input wire logic [1:0]        TAPE_UNIT,
   input wire logic [3:0]        TAPE_MOTION,
   input wire logic              TAPE_MOTION_GO,
   input wire logic [CHAR_W-1:0] TAPE_WR_CHAR,
   input wire logic              TAPE_WR_VALID,
   input wire logic              TAPE_WR_READY
);
   reg [1:0] up;                                // Edges since reset release
   wire      adr;                               // Strobe addressed to this controller
   // Trust the synced equipment number only once it has settled
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) up <= 2'h0;
      else if (up != 2'h3) up <= up + 2'h1;
   end
   assign adr = HQ_STROBE && HQ_FUNC[15:11] == 5'h00 && HQ_FUNC[10:7] == EQUIP_NUM && up == 2'h3;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   a_one_answer: assert property (!(HQ_REPLY && HQ_REJECT)) else $error("reply and reject together");
   a_upper_zero: assert property (HQ_STROBE && HQ_FUNC[15:11] != 5'h00 |=> !HQ_REPLY && !HQ_REJECT)
      else $error("answer with upper bits set");
   a_equip_hit: assert property (adr |=> HQ_REPLY ^ HQ_REJECT) else $error("addressed strobe unanswered");
   a_equip_miss: assert property (HQ_STROBE && HQ_FUNC[10:7] != EQUIP_NUM && up == 2'h3
      |=> !HQ_REPLY && !HQ_REJECT) else $error("answer to other equipment");
   a_idle_quiet: assert property (!HQ_STROBE |=> !HQ_REPLY && !HQ_REJECT) else $error("answer without strobe");
   a_unit_sel: assert property (adr && HQ_OUTPUT && HQ_FUNC[1:0] == 2'h2
      |=> HQ_REPLY && TAPE_UNIT == $past(HQ_DATA[1:0])) else $error("unit select not taken");
   a_stat_two: assert property (adr && !HQ_OUTPUT && HQ_FUNC[1:0] == 2'h2
      |=> HQ_REPLY && HQ_RDATA == {8'h00, TAPE_MOTION, 2'h0, TAPE_UNIT}) else $error("status two wrong");
   a_motion_go: assert property (TAPE_MOTION_GO |-> TAPE_MOTION != 4'h0
      && $past(adr && HQ_OUTPUT && HQ_FUNC[1:0] == 2'h1)) else $error("motion start without control");
   a_sa_hold: assert property (SA_REQ && !SA_ACK |=> SA_REQ && $stable(SA_ADDR)
      && $stable(SA_WRITE) && $stable(SA_WDATA)) else $error("storage request changed early");
   a_sa_drop: assert property (SA_REQ && SA_ACK |=> !SA_REQ) else $error("storage request kept");
   a_char_hold: assert property (TAPE_WR_VALID && !TAPE_WR_READY |=> TAPE_WR_VALID
      && $stable(TAPE_WR_CHAR)) else $error("tape character changed early");
endmodule // tchcd_properties
bind tchcd_top tchcd_properties #(.CHAR_W(CHAR_W)) u_props (.CLK, .RST_N, .EQUIP_NUM, .HQ_STROBE,
   .HQ_OUTPUT, .HQ_FUNC, .HQ_DATA, .HQ_REPLY, .HQ_REJECT, .HQ_RDATA, .SA_REQ, .SA_WRITE, .SA_ADDR,
   .SA_WDATA, .SA_ACK, .TAPE_UNIT, .TAPE_MOTION, .TAPE_MOTION_GO, .TAPE_WR_CHAR, .TAPE_WR_VALID,
   .TAPE_WR_READY);

// ---- tb/testbench.sv ----
// Self-checking bench for the tape controller host command decoder
`timescale 1ns/1ps
module testbench;
   localparam [3:0]  EQ = 4'hA;                 // Jumpered equipment number
   localparam [15:0] LEGAL = 16'h11EF;          // Accepted motion codes
   reg CLK, RST_N, HQ_STROBE, HQ_OUTPUT, TAPE_WR_READY, TAPE_RD_VALID, hold_wr;
   reg [15:0] HQ_FUNC, HQ_DATA, d;
   reg [7:0] TAPE_RD_CHAR;
   reg [1:0] lat;
   reg [31:0] seed, rs;                         // Stimulus and tape-side random state
   reg [15:0] w [0:4];                          // Words sent toward tape
   integer n_fail, comparisons, sa_n, i;
   reg [7:0] wq [$], rq [$];                    // Written and pending read characters
   wire HQ_REPLY, HQ_REJECT, SA_REQ, SA_WRITE, SA_ACK, TAPE_MOTION_GO, TAPE_WR_VALID, TAPE_RD_READY;
   wire [15:0] HQ_RDATA, SA_ADDR, SA_WDATA, SA_RDATA;
   wire [1:0] TAPE_UNIT;
   wire [3:0] TAPE_MOTION;
   wire [7:0] TAPE_WR_CHAR;
   tchcd_top u_tchcd_top (.CLK, .RST_N, .EQUIP_NUM(EQ), .HQ_STROBE, .HQ_OUTPUT, .HQ_FUNC, .HQ_DATA,
      .HQ_REPLY, .HQ_REJECT, .HQ_RDATA, .SA_REQ, .SA_WRITE, .SA_ADDR, .SA_WDATA, .SA_ACK, .SA_RDATA,
      .TAPE_UNIT, .TAPE_MOTION, .TAPE_MOTION_GO, .TAPE_WR_CHAR, .TAPE_WR_VALID, .TAPE_WR_READY,
      .TAPE_RD_CHAR, .TAPE_RD_VALID, .TAPE_RD_READY, .TAPE_EOP(1'b0));
   tchcd_mem_model u_tchcd_mem_model (.clk(CLK), .rst_n(RST_N), .lat(lat), .sa_req(SA_REQ),
      .sa_write(SA_WRITE), .sa_addr(SA_ADDR), .sa_wdata(SA_WDATA), .sa_ack(SA_ACK), .sa_rdata(SA_RDATA));
   // Xorshift step
   function [31:0] xs(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13);
         y = y ^ (y >> 17);
         xs = y ^ (y << 5);
      end
   endfunction
   // Expected second status word
   function [15:0] st2(input [3:0] m, input [1:0] u);
      st2 = {8'h00, m, 2'h0, u};
   endfunction
   task test_done;
      begin
         $display("TB: checks=%0d fails=%0d", comparisons, n_fail);
         if (n_fail == 0 && comparisons > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // One host instruction; ex is {reject, reply} expected
   task issue(input o, input [1:0] op, input [4:0] hi, input [3:0] eq, input [15:0] dt, input [1:0] ex);
      begin
         seed = xs(seed);
         @(posedge CLK);
         HQ_STROBE <= 1'b1;
         HQ_OUTPUT <= o;
         HQ_DATA <= dt;
         HQ_FUNC <= {hi, eq, seed[4:0], op};
         @(posedge CLK);
         HQ_STROBE <= 1'b0;
         #1 chk({14'h0, HQ_REJECT, HQ_REPLY}, {14'h0, ex});
      end
   endtask
   task wait_wq(input integer n);
      integer k;
      begin
         k = 0;
         while (wq.size() < n && k < 300) begin
            @(posedge CLK);
            k = k + 1;
         end
         chk(wq.size(), n);
      end
   endtask
   task do_reset;
      begin
         RST_N <= 1'b0;
         repeat (5) @(posedge CLK);
         RST_N <= 1'b1;
         repeat (3) @(posedge CLK);
         wq.delete();
      end
   endtask
   // Clock
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   // Tape drive: random stalls on writes, queued characters on reads
   always @(posedge CLK) begin
      if (TAPE_WR_VALID && TAPE_WR_READY) wq.push_back(TAPE_WR_CHAR);
      if (TAPE_RD_VALID && TAPE_RD_READY) void'(rq.pop_front());
      rs = xs(rs);
      TAPE_WR_READY <= rs[0] & !hold_wr;
      lat <= rs[2:1];
      TAPE_RD_VALID <= (rq.size() != 0);
      TAPE_RD_CHAR <= (rq.size() != 0) ? rq[0] : ~TAPE_RD_CHAR;
      if (SA_REQ && SA_ACK) sa_n = sa_n + 1;
   end
   // Watchdog
   initial begin
      #400000;
      n_fail = n_fail + 1;
      test_done;
   end
   initial begin
      seed = 32'h0000_0162; rs = xs(32'h0000_0162); n_fail = 0; comparisons = 0; sa_n = 0;
      RST_N = 1'b0; HQ_STROBE = 1'b0; HQ_OUTPUT = 1'b0; HQ_FUNC = 16'h0000; HQ_DATA = 16'h0000;
      TAPE_WR_READY = 1'b0; TAPE_RD_VALID = 1'b0; TAPE_RD_CHAR = 8'h00; lat = 2'h0; hold_wr = 1'b0;
      do_reset;
      // Selection by upper bits and equipment number
      issue(1'b0, 2'h1, 5'h00, EQ, 16'h0000, 2'h1);
      chk(HQ_RDATA & 16'hFFC1, 16'h0001);
      for (i = 0; i < 8; i = i + 1) begin
         seed = xs(seed);
         issue(seed[5], seed[7:6], seed[12:8] | 5'h01, EQ, seed[31:16], 2'h0);
         issue(seed[5], seed[7:6], 5'h00, EQ ^ (seed[11:8] | 4'h1), seed[31:16], 2'h0);
      end
      // Every drive selected and read back
      for (i = 0; i < 4; i = i + 1) begin
         issue(1'b1, 2'h2, 5'h00, EQ, {seed[31:18], i[1:0]}, 2'h1);
         chk({14'h0, TAPE_UNIT}, {14'h0, i[1:0]});
         issue(1'b0, 2'h2, 5'h00, EQ, 16'h0000, 2'h1);
         chk(HQ_RDATA, st2(4'h0, i[1:0]));
      end
      for (i = 0; i < 16; i = i + 1)
         if (!LEGAL[i]) issue(1'b1, 2'h1, 5'h00, EQ, {5'h00, i[3:0], 7'h00}, 2'h2);
      // Direct write
      issue(1'b0, 2'h0, 5'h00, EQ, 16'h0000, 2'h2);
      issue(1'b1, 2'h1, 5'h00, EQ, 16'h0080, 2'h1);
      chk({12'h0, TAPE_MOTION}, 16'h0001);
      for (i = 0; i < 5; i = i + 1) begin
         seed = xs(seed);
         w[i] = seed[15:0];
         if (i == 4) hold_wr <= 1'b1;
         issue(1'b1, 2'h0, 5'h00, EQ, w[i], 2'h1);
         if (i == 4) issue(1'b1, 2'h0, 5'h00, EQ, ~w[i], 2'h2);
         hold_wr <= 1'b0;
         wait_wq(2 * (i + 1));
         chk({wq[2*i], wq[2*i+1]}, w[i]);
         repeat (2) @(posedge CLK);
      end
      chk(sa_n, 0);
      // Direct read
      issue(1'b1, 2'h1, 5'h00, EQ, 16'h0100, 2'h1);
      issue(1'b1, 2'h0, 5'h00, EQ, 16'h1234, 2'h2);
      issue(1'b0, 2'h0, 5'h00, EQ, 16'h0000, 2'h2);
      d = seed[31:16];
      rq.push_back(d[15:8]);
      rq.push_back(d[7:0]);
      repeat (10) @(posedge CLK);
      issue(1'b0, 2'h0, 5'h00, EQ, 16'h0000, 2'h1);
      chk(HQ_RDATA, d);
      // Buffered write of two words, with a second start refused
      do_reset;
      u_tchcd_mem_model.mem[8'h1F] = 16'h0022;
      u_tchcd_mem_model.mem[8'h20] = w[0];
      u_tchcd_mem_model.mem[8'h21] = w[1];
      issue(1'b1, 2'h3, 5'h00, EQ, 16'h0020, 2'h1);
      issue(1'b1, 2'h3, 5'h00, EQ, 16'h0020, 2'h2);
      repeat (8) @(posedge CLK);                // End address fetch done before motion
      issue(1'b1, 2'h1, 5'h00, EQ, 16'h0080, 2'h1);
      wait_wq(4);
      chk({wq[0], wq[1]}, w[0]);
      chk({wq[2], wq[3]}, w[1]);
      repeat (5) @(posedge CLK);
      chk(sa_n, 3);
      issue(1'b0, 2'h3, 5'h00, EQ, 16'h0000, 2'h1);
      chk(HQ_RDATA, 16'h0022);
      issue(1'b0, 2'h1, 5'h00, EQ, 16'h0000, 2'h1);
      chk(HQ_RDATA & 16'h0001, 16'h0001);
      // Buffered read of one word into storage
      u_tchcd_mem_model.mem[8'h2F] = 16'h0031;
      issue(1'b1, 2'h3, 5'h00, EQ, 16'h0030, 2'h1);
      repeat (8) @(posedge CLK);
      issue(1'b1, 2'h1, 5'h00, EQ, 16'h0100, 2'h1);
      rq.push_back(~d[15:8]);
      rq.push_back(~d[7:0]);
      repeat (20) @(posedge CLK);
      chk(u_tchcd_mem_model.mem[8'h30], ~d);
      chk(sa_n, 5);
      test_done;
   end
endmodule // testbench
